// ---- rtl/itas_pkg.sv ----
// Package for the input trigger action selector: types and constants.
// Assumes a single system clock and a synchronous active-low reset.
package itas_pkg;

  // Trigger type selection; any code beyond the three types fires nothing.
  typedef enum logic [1:0] {
    TRIG_EDGE,
    TRIG_TOGGLE,
    TRIG_ALTERN
  } itas_trig_t;

  // Which of the two configured actions is next in turn.
  typedef enum logic {
    TURN_FIRST,
    TURN_SECOND
  } itas_turn_t;

  // Configuration carried into the block.
  typedef struct packed {
    itas_trig_t trig;       // Trigger type.
    logic       level_high; // Active level: 1 is High, 0 is Low.
  } itas_cfg_t;

  // Action request pulses.
  typedef struct packed {
    logic act1; // Request for the first action.
    logic act2; // Request for the second action.
  } itas_req_t;

  // Reset values.
  localparam itas_cfg_t  CFG_RST  = '{trig: TRIG_EDGE, level_high: 1'h1};
  localparam itas_req_t  REQ_RST  = '{act1: 1'h0, act2: 1'h0};
  localparam itas_turn_t TURN_RST = TURN_FIRST;
  localparam logic       LVL_RST  = 1'h0;

  // Cycles after reset release before edges are trusted; three lets the previous
  // sample take the input's level, so a level held through reset is no edge.
  localparam logic [1:0] ARM_CYCLES = 2'h3;
  localparam logic [1:0] ARM_RST    = 2'h0;
  localparam logic [1:0] ARM_STEP   = 2'h1;

endpackage

// ---- rtl/itas_sync.sv ----
// Synchroniser and edge detector for the user input.
// Assumes the input may change at any time relative to the system clock.
module itas_sync
  import itas_pkg::*;
(
  input  wire logic i_clk,   // System clock.
  input  wire logic i_rst_b, // Synchronous reset, active low.
  input  wire logic i_async, // Raw user input.
  output logic      o_level, // Synchronised level.
  output logic      o_rise,  // One-cycle pulse on a low-to-high change.
  output logic      o_fall   // One-cycle pulse on a high-to-low change.
);

  logic       meta;
  logic       sync;
  logic       prev;
  logic [1:0] arm;

  // Two-stage synchroniser; the first stage feeds only the second.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta <= LVL_RST;
      sync <= LVL_RST;
    end else begin
      meta <= i_async;
      sync <= meta;
    end
  end

  // Previous synchronised sample for transition detection.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prev <= LVL_RST;
    end else begin
      prev <= sync;
    end
  end

  // Arming delay keeps the reset value of the pipe from looking like an edge.
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      arm <= ARM_RST;
    end else if (arm != ARM_CYCLES) begin
      arm <= arm + ARM_STEP;
    end
  end

  // Transitions come from comparing consecutive samples.
  assign o_level = sync;
  assign o_rise  = (arm == ARM_CYCLES) && sync && !prev;  // [RULE9]
  assign o_fall  = (arm == ARM_CYCLES) && !sync && prev;  // [RULE9]

endmodule

// ---- rtl/itas_top.sv ----
// Input trigger action selector: turns one user input into action requests.
// Assumes the input comes from an outside contact, asynchronous to the clock.
// Behaviour
// [RULE1] Three trigger types are offered, edge, level toggle and level alternative.
// [RULE2] Edge type with level High requests the first action on every rising change.
// [RULE3] Edge type with level Low requests the first action on every falling change.
// [RULE4] Level toggle fires on every change and alternates between first and second action.
// [RULE5] Level toggle with level High follows a rising first action with a falling second.
// [RULE6] Level alternative with level High fires on rising changes and ignores falling ones.
// [RULE7] Level alternative with level Low fires on falling changes and ignores rising ones.
// [RULE8] Level alternative requests first then second action on successive accepted changes.
// [RULE9] The input is synchronised, edges come from consecutive samples, requests are pulses.
module itas_top
  import itas_pkg::*;
(
  input  wire logic      I_CLK_SYS,    // System clock, 10 MHz.
  input  wire logic      I_RST_B,      // Synchronous reset, active low.
  input  wire logic      I_USER_IN,    // Raw user input.
  input  wire itas_cfg_t I_CFG,        // Trigger type and active level.
  output itas_req_t      O_REQ,        // Registered one-cycle action requests.
  output logic           O_NEXT_SECOND // High when the second action is next.
);

  logic       lvl;
  logic       rise;
  logic       fall;
  itas_cfg_t  cfg_prev;
  logic       cfg_changed;
  itas_turn_t turn;
  itas_turn_t eff_turn;
  itas_turn_t next_turn;
  logic       fire;
  itas_req_t  next_req;

  // Decides whether a detected transition is accepted under the configuration.
  function automatic logic accept(input itas_cfg_t cfg, input logic r, input logic f);
    case (cfg.trig)
      TRIG_EDGE:   accept = cfg.level_high ? r : f;  // [RULE2] [RULE3]
      TRIG_TOGGLE: accept = r || f;                  // [RULE4]
      TRIG_ALTERN: accept = cfg.level_high ? r : f;  // [RULE6] [RULE7]
      default:     accept = 1'h0;
    endcase
  endfunction

  // Tells whether the trigger type alternates between the two actions.
  function automatic logic alternates(input itas_trig_t t);
    alternates = (t == TRIG_TOGGLE) || (t == TRIG_ALTERN);
  endfunction

  // Synchroniser and transition detector.
  itas_sync itas_sync_inst (
    .i_clk   (I_CLK_SYS),
    .i_rst_b (I_RST_B),
    .i_async (I_USER_IN),
    .o_level (lvl),
    .o_rise  (rise),
    .o_fall  (fall)
  );

  // Remembers the configuration so a change restarts the alternation.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      cfg_prev <= CFG_RST;
    end else begin
      cfg_prev <= I_CFG;
    end
  end

  // A new configuration always starts with the first action.
  assign cfg_changed = (I_CFG != cfg_prev);
  assign eff_turn    = cfg_changed ? TURN_FIRST : turn;
  assign fire        = accept(I_CFG, rise, fall);  // [RULE1]

  // Next turn: flips on each accepted change in the alternating types.
  always_comb begin
    next_turn = eff_turn;
    if (fire && alternates(I_CFG.trig)) begin
      case (eff_turn)
        TURN_FIRST:  next_turn = TURN_SECOND;  // [RULE4] [RULE5] [RULE8]
        TURN_SECOND: next_turn = TURN_FIRST;   // [RULE4] [RULE8]
        default:     next_turn = TURN_FIRST;
      endcase
    end
  end

  // Turn state register.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      turn <= TURN_RST;
    end else begin
      turn <= next_turn;
    end
  end

  // Request decode: edge type always asks for the first action.
  always_comb begin
    next_req      = REQ_RST;
    next_req.act1 = fire && (!alternates(I_CFG.trig) || eff_turn == TURN_FIRST); // [RULE2]
    next_req.act2 = fire && alternates(I_CFG.trig) && eff_turn == TURN_SECOND;   // [RULE5]
  end

  // Request pulses are registered and last one cycle per accepted change.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_B) begin
      O_REQ <= REQ_RST;
    end else begin
      O_REQ <= next_req;  // [RULE9]
    end
  end

  assign O_NEXT_SECOND = (turn == TURN_SECOND);

  // Checks on the request behaviour.
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);

  chk_edge_high_rise: assert property ( // [RULE2]
    rise && I_CFG.trig == TRIG_EDGE && I_CFG.level_high |=> O_REQ.act1 && !O_REQ.act2)
    else $error("Edge type with level High missed a rising change.");

  chk_edge_low_fall: assert property ( // [RULE3]
    fall && I_CFG.trig == TRIG_EDGE && !I_CFG.level_high |=> O_REQ.act1 && !O_REQ.act2)
    else $error("Edge type with level Low missed a falling change.");

  chk_edge_no_second: assert property ( // [RULE1]
    O_REQ.act2 |-> $past(I_CFG.trig) != TRIG_EDGE && $past(I_CFG.trig) != 2'h3)
    else $error("Second action requested outside an alternating type.");

  chk_toggle_every_change: assert property ( // [RULE4]
    I_CFG.trig == TRIG_TOGGLE && (rise || fall) |=> O_REQ.act1 != O_REQ.act2)
    else $error("Level toggle did not request exactly one action on a change.");

  sequence toggle_high_rise_first;
    I_CFG.trig == TRIG_TOGGLE && I_CFG.level_high && rise && eff_turn == TURN_FIRST;
  endsequence

  chk_toggle_rise_fall: assert property ( // [RULE5]
    toggle_high_rise_first ##1 (fall && !cfg_changed) |=> O_REQ.act2 && !O_REQ.act1)
    else $error("Falling change after a toggle rise did not request the second action.");

  chk_alt_high_ignore: assert property ( // [RULE6]
    I_CFG.trig == TRIG_ALTERN && I_CFG.level_high && fall |=> !O_REQ.act1 && !O_REQ.act2)
    else $error("Level alternative with level High acted on a falling change.");

  chk_alt_low_ignore: assert property ( // [RULE7]
    I_CFG.trig == TRIG_ALTERN && !I_CFG.level_high && rise |=> !O_REQ.act1 && !O_REQ.act2)
    else $error("Level alternative with level Low acted on a rising change.");

  chk_alt_turn_order: assert property ( // [RULE8]
    I_CFG.trig == TRIG_ALTERN && fire |=>
      (O_REQ.act2 == ($past(eff_turn) == TURN_SECOND)) && (O_REQ.act1 || O_REQ.act2)
      && (O_NEXT_SECOND == ($past(eff_turn) == TURN_FIRST)))
    else $error("Level alternative requested the wrong action in turn.");

  chk_req_single_pulse: assert property ( // [RULE9]
    (O_REQ.act1 || O_REQ.act2) |-> !(O_REQ.act1 && O_REQ.act2) && $past(rise || fall))
    else $error("Action request without a preceding transition or with both actions.");

  chk_sync_latency: assert property ( // [RULE9]
    $rose(lvl) && $past(I_RST_B, 3) && I_CFG.trig == TRIG_EDGE && I_CFG.level_high
      |=> O_REQ.act1)
    else $error("Synchronised rise did not lead to a request on the next cycle.");

  // Edge type ignores the opposite change and never moves the turn.
  chk_edge_high_ignore: assert property ( // [RULE2]
    fall && I_CFG.trig == TRIG_EDGE && I_CFG.level_high |=> !O_REQ.act1 && !O_REQ.act2)
    else $error("Edge type with level High acted on a falling change.");

  chk_edge_low_ignore: assert property ( // [RULE3]
    rise && I_CFG.trig == TRIG_EDGE && !I_CFG.level_high |=> !O_REQ.act1 && !O_REQ.act2)
    else $error("Edge type with level Low acted on a rising change.");

  chk_edge_turn_hold: assert property ( // [RULE2]
    I_CFG.trig == TRIG_EDGE && !cfg_changed |=> $stable(O_NEXT_SECOND))
    else $error("Edge type moved the turn between the two actions.");

  chk_off_silent: assert property ( // [RULE1]
    I_CFG.trig == 2'h3 |=> !O_REQ.act1 && !O_REQ.act2)
    else $error("The unused type code requested an action.");

  // Level toggle picks the action from the turn, whatever the level.
  chk_toggle_first_turn: assert property ( // [RULE4]
    I_CFG.trig == TRIG_TOGGLE && fire && eff_turn == TURN_FIRST
      |=> O_REQ.act1 && !O_REQ.act2)
    else $error("Level toggle did not request the first action in its turn.");

  chk_toggle_second_turn: assert property ( // [RULE4]
    I_CFG.trig == TRIG_TOGGLE && fire && eff_turn == TURN_SECOND
      |=> O_REQ.act2 && !O_REQ.act1)
    else $error("Level toggle did not request the second action in its turn.");

  chk_toggle_low_fall: assert property ( // [RULE4]
    I_CFG.trig == TRIG_TOGGLE && !I_CFG.level_high && fall |=> O_REQ.act1 || O_REQ.act2)
    else $error("Level toggle with level Low missed a falling change.");

  // Level alternative acts on one direction and keeps the turn on the other.
  chk_alt_high_accept: assert property ( // [RULE6]
    I_CFG.trig == TRIG_ALTERN && I_CFG.level_high && rise |=> O_REQ.act1 || O_REQ.act2)
    else $error("Level alternative with level High missed a rising change.");

  chk_alt_low_accept: assert property ( // [RULE7]
    I_CFG.trig == TRIG_ALTERN && !I_CFG.level_high && fall |=> O_REQ.act1 || O_REQ.act2)
    else $error("Level alternative with level Low missed a falling change.");

  chk_alt_high_hold: assert property ( // [RULE6]
    I_CFG.trig == TRIG_ALTERN && I_CFG.level_high && fall && !cfg_changed
      |=> $stable(O_NEXT_SECOND))
    else $error("Level alternative with level High moved the turn on a falling change.");

  chk_alt_low_hold: assert property ( // [RULE7]
    I_CFG.trig == TRIG_ALTERN && !I_CFG.level_high && rise && !cfg_changed
      |=> $stable(O_NEXT_SECOND))
    else $error("Level alternative with level Low moved the turn on a rising change.");

  // Requests need an accepted change, and a new configuration starts first.
  chk_req_quiet: assert property ( // [RULE9]
    !fire |=> !O_REQ.act1 && !O_REQ.act2)
    else $error("Action requested without an accepted change.");

  chk_cfg_restart: assert property ( // [RULE8]
    cfg_changed && fire |=> O_REQ.act1 && !O_REQ.act2)
    else $error("A new configuration did not start with the first action.");

  cov_edge_fire:   cover property (I_CFG.trig == TRIG_EDGE && O_REQ.act1);
  cov_toggle_pair: cover property (I_CFG.trig == TRIG_TOGGLE && O_REQ.act1 ##[1:50] O_REQ.act2);
  cov_alt_second:  cover property (I_CFG.trig == TRIG_ALTERN && O_REQ.act2);
  cov_cfg_change:  cover property (cfg_changed && fire);
  cov_alt_low_first: cover property (I_CFG.trig == TRIG_ALTERN && !I_CFG.level_high && O_REQ.act1);

endmodule

// ---- sim/itas_contact.sv ----
// Model of the outside contact that drives the user input.
// Assumes the bench asks for each new level; the contact holds it until told.
module itas_contact (
  input  wire logic i_clk, // System clock, used only to time changes.
  output logic      o_pin  // Level seen by the user input.
);
  timeunit 1ns;
  timeprecision 1ns;

  // The contact rests open, reading low, until the bench moves it.
  initial begin
    o_pin = 1'h0;
  end

  // Moves the contact to a new level just after a falling clock edge.
  task automatic move(input logic v);
    @(negedge i_clk);
    o_pin = v;
  endtask
endmodule

// ---- sim/test_input_trigger_action_select.sv ----
// Self-checking bench for the input trigger action selector.
// Assumes a contact model drives the user input and the design answers in fixed cycles.
module test_input_trigger_action_select
  import itas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic      clk_sys;     // System clock.
  logic      rst_b;       // Reset, active low.
  logic      user_in;     // Contact level.
  itas_cfg_t cfg;         // Trigger configuration.
  itas_req_t req;         // Action requests.
  logic      next_second; // Second action is next.
  int        bad_count;   // Mismatches seen.
  int        n_compared;  // Comparisons made.

  // Clock of 100 ns period.
  initial begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  itas_contact itas_contact_inst (.i_clk(clk_sys), .o_pin(user_in));
  itas_top itas_top_inst (.I_CLK_SYS(clk_sys), .I_RST_B(rst_b), .I_USER_IN(user_in),
    .I_CFG(cfg), .O_REQ(req), .O_NEXT_SECOND(next_second));

  // Compares a value seen with the value expected.
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Applies a configuration and lets the design settle on it.
  task automatic set_cfg(input itas_trig_t trig, input logic lvl);
    @(negedge clk_sys);
    cfg = '{trig: trig, level_high: lvl};
    repeat (3) @(negedge clk_sys);
  endtask

  // Moves the input (and back again next cycle when fast), then counts pulses.
  task automatic step(input logic v, input logic fast, input logic [3:0] exp);
    logic [1:0] n1;
    logic [1:0] n2;
    n1 = 2'h0;
    n2 = 2'h0;
    itas_contact_inst.move(v);
    if (fast) begin
      itas_contact_inst.move(!v);
    end
    repeat (6) begin
      @(negedge clk_sys);
      n1 += req.act1;
      n2 += req.act2;
    end
    check({n1, n2}, exp);
  endtask

  // Edge type, both active levels.
  task automatic t_edge();
    set_cfg(TRIG_EDGE, 1'h1);
    step(1'h1, 1'h0, 4'h4);
    step(1'h0, 1'h0, 4'h0);
    set_cfg(TRIG_EDGE, 1'h0);
    step(1'h1, 1'h0, 4'h0);
    step(1'h0, 1'h0, 4'h4);
  endtask

  // Level toggle, including two changes on consecutive cycles.
  task automatic t_toggle();
    set_cfg(TRIG_TOGGLE, 1'h1);
    step(1'h1, 1'h0, 4'h4);
    check({3'h0, next_second}, 4'h1);
    step(1'h0, 1'h0, 4'h1);
    step(1'h1, 1'h1, 4'h5);
  endtask

  // Level alternative, level Low then level High.
  task automatic t_altern();
    set_cfg(TRIG_ALTERN, 1'h0);
    step(1'h1, 1'h0, 4'h0);
    step(1'h0, 1'h0, 4'h4);
    step(1'h1, 1'h0, 4'h0);
    step(1'h0, 1'h0, 4'h1);
    check({3'h0, next_second}, 4'h0);
    set_cfg(TRIG_ALTERN, 1'h1);
    step(1'h1, 1'h0, 4'h4);
    step(1'h0, 1'h0, 4'h0);
  endtask

  // The unused type code fires nothing.
  task automatic t_off();
    set_cfg(itas_trig_t'(2'h3), 1'h1);
    step(1'h1, 1'h1, 4'h0);
  endtask

  // Reset in mid-run with the input held high: the turn restarts and the level is no edge.
  task automatic t_reset();
    logic [1:0] n1;
    logic [1:0] n2;
    n1 = 2'h0;
    n2 = 2'h0;
    set_cfg(TRIG_TOGGLE, 1'h1);
    step(1'h1, 1'h0, 4'h4);
    @(negedge clk_sys);
    rst_b = 1'h0;
    repeat (2) @(negedge clk_sys);
    check({1'h0, req, next_second}, 4'h0);
    rst_b = 1'h1;
    repeat (6) begin
      @(negedge clk_sys);
      n1 += req.act1;
      n2 += req.act2;
    end
    check({n1, n2}, 4'h0);
    check({3'h0, next_second}, 4'h0);
    step(1'h0, 1'h0, 4'h4);
  endtask

  // Main sequence: reset, then every scenario.
  initial begin
    bad_count = 0;
    n_compared = 0;
    cfg = CFG_RST;
    rst_b = 1'h0;
    repeat (12) @(negedge clk_sys);
    check({1'h0, req, next_second}, 4'h0);
    rst_b = 1'h1;
    repeat (4) @(negedge clk_sys);
    t_edge();
    t_toggle();
    t_altern();
    t_off();
    t_reset();
    summarize();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    summarize();
  end
endmodule
